// [dv/imrd_checker.sv]
/*
 holds assertions on the ports of the remap decoder.
 assumes a bind from the bench and clkEn held high.
*/
`timescale 1ns/1ps
module imrd_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cpuGnt,
    input wire logic dmaGnt,
    input wire logic cpuDone,
    input wire logic dmaDone,
    input wire logic cpuAbort,
    input wire logic dmaAbort,
    input wire logic [31:0] memAddr,
    input wire logic [1:0] memSize,
    input wire logic memWrite,
    input wire logic remapped,
    input wire logic flashSel,
    input wire logic sramSel,
    input wire logic romSel,
    input wire logic romEnable,
    input wire logic [1:0] flashWaitStates
);
    // ==========
    // helpers
    wire gnt = cpuGnt | dmaGnt;
    wire area0 = memAddr[31:20] == 12'h000;
    wire alOk = memSize == 2'h0 || (memSize == 2'h1 && !memAddr[0])
        || (memSize == 2'h2 && memAddr[1:0] == 2'h0);
    wire hit = gnt && alOk && memAddr[31:28] == 4'h0;
    wire anyDone = cpuDone | dmaDone;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ==========
    // properties
    property p_boot; hit && area0 && !remapped |-> flashSel && !sramSel; endproperty
    a_boot: assert property (p_boot) else $error("zero area off flash");
    property p_remap; hit && area0 && remapped |-> sramSel && !flashSel; endproperty
    a_remap: assert property (p_remap) else $error("zero area off sram");
    property p_flash; hit && memAddr[27:20] == 8'h01 |-> flashSel; endproperty
    a_flash: assert property (p_flash) else $error("flash area lost");
    property p_rom; !romEnable |-> !romSel; endproperty
    a_rom: assert property (p_rom) else $error("rom mapped");
    property p_align; dmaGnt && !alOk |-> dmaAbort && !flashSel && !sramSel; endproperty
    a_align: assert property (p_align) else $error("misaligned not aborted");
    property p_gnt; !(cpuGnt && dmaGnt); endproperty
    a_gnt: assert property (p_gnt) else $error("two grants");
    // only a count of three is watched; the bench compares read data, abort status and the remap flag and checks no other count
    property p_wait;
        $rose(flashSel) && !memWrite && flashWaitStates == 2'h3 |-> !anyDone [*3] ##1 anyDone;
    endproperty
    a_wait: assert property (p_wait) else $error("flash wait count wrong");
    property p_undef; hit && memAddr[27:20] > 8'h03 |-> cpuAbort || dmaAbort; endproperty
    a_undef: assert property (p_undef) else $error("undefined area not aborted");
    property p_sticky; remapped |=> remapped; endproperty
    a_sticky: assert property (p_sticky) else $error("remap lost");
endmodule

// [dv/imrd_mem_model.sv]
/*
 holds a behavioural model of the memories and peripheral behind the decoder.
 assumes selects and address come straight from the decoder.
*/
`timescale 1ns/1ps
module imrd_mem_model (
    input wire logic clk_sys,
    input wire logic [31:0] memAddr,
    input wire logic flashSel,
    input wire logic sramSel,
    input wire logic romSel,
    input wire logic periphSel,
    output logic [31:0] flashRdata,
    output logic [31:0] sramRdata,
    output logic [31:0] romRdata,
    output logic [31:0] periphRdata,
    output logic periphReady
);
    logic [1:0] waitCnt = 2'h0;
    // unselected memories show inverted data so stale values never match
    assign flashRdata = {8'h1f, memAddr[23:0]} ^ {32{!flashSel}};
    assign sramRdata = {8'h2a, memAddr[23:0]} ^ {32{!sramSel}};
    assign romRdata = {8'h3c, memAddr[23:0]} ^ {32{!romSel}};
    assign periphRdata = {8'h4d, memAddr[23:0]} ^ {32{!periphSel}};
    // slow peripheral: ready on the third selected cycle
    always_ff @(posedge clk_sys) waitCnt <= periphSel ? waitCnt + 2'h1 : 2'h0;
    assign periphReady = periphSel && waitCnt == 2'h2;
endmodule

// [dv/testbench.sv]
/*
 holds the self-checking bench of the remap decoder.
 assumes the memory model answers reads with a tag byte per memory.
*/
`timescale 1ns/1ps
`include "imrd_defines.svh"
module testbench;
    logic clk_sys = 1'h0, arst_n = 1'h0, clkEn = 1'h1, cpuData = 1'h1;
    logic cpuReq = 1'h0, cpuWrite = 1'h0, dmaReq = 1'h0, dmaWrite = 1'h0;
    logic remapCmd = 1'h0, romEnable = 1'h0, abortClear = 1'h0;
    logic [31:0] cpuAddr = 32'h0, cpuWdata = 32'h0, dmaAddr = 32'h0, dmaWdata = 32'h0;
    logic [1:0] cpuSize = 2'h0, dmaSize = 2'h0, flashWaitStates = 2'h3;
    logic cpuGnt, cpuDone, cpuAbort, dmaGnt, dmaDone, dmaAbort, remapped, flashSel, sramSel;
    logic romSel, periphSel, memWrite, abortValid, abortFromDma, abortWrite, periphReady;
    logic [1:0] memSize, abortType, abortSize;
    logic [31:0] rdData, memAddr, memWdata, abortAddr, flashRdata, sramRdata, romRdata;
    logic [31:0] periphRdata;
    int failures = 0, compares = 0, cycles = 0;
    imrd_remap_decoder u_dut (.clk_sys, .arst_n, .clkEn, .cpuReq, .cpuAddr, .cpuWrite,
        .cpuData, .cpuSize, .cpuWdata, .cpuGnt, .cpuDone, .cpuAbort, .dmaReq, .dmaAddr,
        .dmaWrite, .dmaSize, .dmaWdata, .dmaGnt, .dmaDone, .dmaAbort, .rdData, .remapCmd,
        .romEnable, .flashWaitStates, .remapped, .flashSel, .sramSel, .romSel, .periphSel,
        .memAddr, .memWrite, .memSize, .memWdata, .flashRdata, .sramRdata, .romRdata,
        .periphRdata, .periphReady, .abortValid, .abortFromDma, .abortType, .abortAddr,
        .abortWrite, .abortSize, .abortClear);
    imrd_mem_model u_mem (.clk_sys, .memAddr, .flashSel, .sramSel, .romSel, .periphSel,
        .flashRdata, .sramRdata, .romRdata, .periphRdata, .periphReady);
    always #2.5 clk_sys = ~clk_sys;
    // ==========
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // result is abort flag and tag byte of the answering memory
    task automatic acc(input logic dma, input logic [31:0] a, input logic [1:0] sz,
                       output logic [31:0] res);
        logic abt;
        @(posedge clk_sys);
        if (dma) begin
            dmaReq <= 1'h1;
            dmaAddr <= a;
            dmaSize <= sz;
        end else begin
            cpuReq <= 1'h1;
            cpuAddr <= a;
            cpuSize <= sz;
        end
        for (int n = 0; n < 20; n++) begin
            #1;
            if (dma ? dmaDone | dmaAbort : cpuDone | cpuAbort) break;
            @(posedge clk_sys);
        end
        abt = dma ? dmaAbort : cpuAbort;
        @(posedge clk_sys);
        if (dma) dmaReq <= 1'h0;
        else cpuReq <= 1'h0;
        #1;
        res = abt ? 32'h100 : {24'h0, rdData[31:24]};
    endtask
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_boot();
        logic [31:0] r;
        acc(1'h0, 32'h0000_0000, 2'h2, r);
        chk(r, 32'h1f);
        acc(1'h0, 32'h0020_0000, 2'h2, r);
        chk(r, 32'h2a);
        acc(1'h0, 32'h0010_0006, 2'h1, r);
        chk(r, 32'h1f);
        acc(1'h1, 32'hf000_0000, 2'h2, r);
        chk(r, 32'h4d);
    endtask
    task automatic t_abort();
        logic [31:0] r;
        acc(1'h1, 32'h0050_0000, 2'h2, r);
        chk(r, 32'h100);
        chk({abortFromDma, abortType, abortAddr}, {1'h1, `IMRD_ABT_UNDEF, 32'h0050_0000});
        @(posedge clk_sys);
        abortClear <= 1'h1;
        @(posedge clk_sys);
        abortClear <= 1'h0;
        acc(1'h0, 32'h0020_0001, 2'h1, r);
        chk(r, 32'h100);
        chk({abortValid, abortFromDma, abortType}, {2'h2, `IMRD_ABT_MISALIGN});
        acc(1'h1, 32'h0020_0002, 2'h2, r);
        chk(r, 32'h100);
        chk({abortValid, abortFromDma, abortType, abortSize}, {2'h3, `IMRD_ABT_MISALIGN, 2'h2});
        acc(1'h0, 32'h0030_0000, 2'h2, r);
        chk(r, 32'h100);
    endtask
    task automatic t_rom();
        logic [31:0] r;
        @(posedge clk_sys);
        romEnable <= 1'h1;
        flashWaitStates <= 2'h0;
        acc(1'h0, 32'h0030_0010, 2'h2, r);
        chk(r, 32'h3c);
        acc(1'h1, 32'h0010_0020, 2'h2, r);
        chk(r, 32'h1f);
        @(posedge clk_sys);
        romEnable <= 1'h0;
        flashWaitStates <= 2'h3;
    endtask
    task automatic t_remap();
        logic [31:0] r, q;
        @(posedge clk_sys);
        remapCmd <= 1'h1;
        @(posedge clk_sys);
        remapCmd <= 1'h0;
        acc(1'h1, 32'h0000_0004, 2'h2, r);
        chk(r, 32'h2a);
        acc(1'h0, 32'h0010_0000, 2'h2, r);
        chk(r, 32'h1f);
        fork
            acc(1'h0, 32'h0020_0008, 2'h2, r);
            acc(1'h1, 32'h0000_000c, 2'h2, q);
        join
        chk({r, q}, {32'h2a, 32'h2a});
        chk(remapped, 1'h1);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'h1;
        t_boot();
        t_abort();
        t_rom();
        t_remap();
        test_done();
    end
endmodule
bind imrd_remap_decoder imrd_checker u_chk (.clk_sys, .arst_n, .cpuGnt, .dmaGnt, .cpuDone,
    .dmaDone, .cpuAbort, .dmaAbort, .memAddr, .memSize, .memWrite, .remapped, .flashSel,
    .sramSel, .romSel, .romEnable, .flashWaitStates);

// [hdl/imrd_remap_decoder.sv]
/*
 holds arbiter, address decoder, remap flag, alignment check, abort capture
 and flash wait-state insertion of the internal memory controller.
 assumes memories answer combinationally and masters hold a request until done.
*/
// What this block does
// - before remap, sram only at its base
// - after remap, sram also at zero
// - flash area always selects flash
// - before remap, zero area goes to flash
// - rom unmapped while romEnable is low
// - selects three memory areas, one peripheral area
// - misaligned data access returns abort
// - abort captures source, type, access parameters
// - arbiter grants one master at a time
// - flash reads take zero to three waits
`timescale 1ns/1ps
`include "imrd_defines.svh"

module imrd_remap_decoder
    import imrd_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic cpuReq,
    input wire logic [ADDR_W-1:0] cpuAddr,
    input wire logic cpuWrite,
    input wire logic cpuData,
    input wire logic [1:0] cpuSize,
    input wire logic [DATA_W-1:0] cpuWdata,
    output logic cpuGnt,
    output logic cpuDone,
    output logic cpuAbort,
    input wire logic dmaReq,
    input wire logic [ADDR_W-1:0] dmaAddr,
    input wire logic dmaWrite,
    input wire logic [1:0] dmaSize,
    input wire logic [DATA_W-1:0] dmaWdata,
    output logic dmaGnt,
    output logic dmaDone,
    output logic dmaAbort,
    output logic [DATA_W-1:0] rdData,
    input wire logic remapCmd,
    input wire logic romEnable,
    input wire logic [1:0] flashWaitStates,
    output logic remapped,
    output logic flashSel,
    output logic sramSel,
    output logic romSel,
    output logic periphSel,
    output logic [ADDR_W-1:0] memAddr,
    output logic memWrite,
    output logic [1:0] memSize,
    output logic [DATA_W-1:0] memWdata,
    input wire logic [DATA_W-1:0] flashRdata,
    input wire logic [DATA_W-1:0] sramRdata,
    input wire logic [DATA_W-1:0] romRdata,
    input wire logic [DATA_W-1:0] periphRdata,
    input wire logic periphReady,
    output logic abortValid,
    output logic abortFromDma,
    output logic [1:0] abortType,
    output logic [ADDR_W-1:0] abortAddr,
    output logic abortWrite,
    output logic [1:0] abortSize,
    input wire logic abortClear
);

    initial begin
        if (ADDR_W != 32 || DATA_W < 8) begin
            $error("imrd_remap_decoder: unsupported width");
        end
    end

    // =============================================================
    // helpers
    function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] lo);
        misaligned = (sz == `IMRD_SIZE_HALF && lo[0])
            || (sz == `IMRD_SIZE_WORD && lo != 2'h0);
    endfunction

    // =============================================================
    // state
    imrd_state_type state_reg, state_next;
    logic remap_reg;
    logic owner_reg, owner_next;
    logic lastDma_reg;
    logic [1:0] wait_reg;
    logic [DATA_W-1:0] rd_reg;
    logic abtV_reg, abtDma_reg, abtW_reg;
    logic [1:0] abtT_reg, abtS_reg;
    logic [ADDR_W-1:0] abtA_reg;

    // =============================================================
    // arbitration: round robin so neither master starves
    wire logic pickDma = dmaReq && (!cpuReq || !lastDma_reg);
    wire logic anyReq = cpuReq || dmaReq;
    wire logic idle = (state_reg == IMRD_ST_IDLE);
    wire logic curDma = idle ? pickDma : owner_reg;

    wire logic [ADDR_W-1:0] aSel = curDma ? dmaAddr : cpuAddr;
    wire logic wSel = curDma ? dmaWrite : cpuWrite;
    wire logic [1:0] szSel = curDma ? dmaSize : cpuSize;
    wire logic dataAcc = curDma ? 1'b1 : cpuData;

    // =============================================================
    // address decode
    wire logic [`IMRD_INT_W-1:0] region = aSel[`IMRD_INT_MSB -: `IMRD_INT_W];
    wire logic [`IMRD_AREA_W-1:0] area = aSel[`IMRD_AREA_LSB +: `IMRD_AREA_W];
    wire logic inInt = (region == `IMRD_INT_REGION);
    wire logic isBoot = inInt && area == `IMRD_AREA_BOOT;
    wire logic hitFlash = inInt && area == `IMRD_AREA_FLASH;
    wire logic hitSramB = inInt && area == `IMRD_AREA_SRAM;
    wire logic hitRom = inInt && area == `IMRD_AREA_ROM && romEnable;
    wire logic selFlashC = hitFlash || (isBoot && !remap_reg);
    wire logic selSramC = hitSramB || (isBoot && remap_reg);
    wire logic selPerC = (region == `IMRD_PERIPH_REGION);
    wire logic undefC = !(selFlashC || selSramC || hitRom || selPerC);
    wire logic misC = dataAcc && misaligned(szSel, aSel[1:0]);
    wire logic abortC = misC || undefC;
    wire logic active = !idle || anyReq;
    wire logic flashRd = selFlashC && !wSel;

    // =============================================================
    // sequencing
    wire logic startWait = idle && anyReq && !abortC && flashRd
        && flashWaitStates != 2'h0;
    wire logic waitOver = (state_reg == IMRD_ST_WAIT) && wait_reg == 2'h0;
    wire logic perHold = selPerC && !periphReady && !abortC;
    wire logic perWait = (state_reg == IMRD_ST_DONE);
    wire logic finish = active && !abortC && !perHold
        && ((idle && !startWait) || waitOver || perWait);
    wire logic abortNow = idle && anyReq && abortC;
    wire logic [1:0] wsClamp = (flashWaitStates > `IMRD_WS_MAX) ? `IMRD_WS_MAX : flashWaitStates;

    always_comb begin
        state_next = state_reg;
        owner_next = owner_reg;
        case (state_reg)
            IMRD_ST_IDLE: begin
                owner_next = pickDma;
                if (startWait) begin
                    state_next = IMRD_ST_WAIT;
                end else if (perHold && anyReq) begin
                    state_next = IMRD_ST_DONE;
                end
            end
            IMRD_ST_WAIT: begin
                if (waitOver) begin
                    state_next = IMRD_ST_IDLE;
                end
            end
            IMRD_ST_DONE: begin
                if (!perHold) begin
                    state_next = IMRD_ST_IDLE;
                end
            end
            default: state_next = IMRD_ST_IDLE;
        endcase
    end

    wire logic [DATA_W-1:0] rdMux = selFlashC ? flashRdata
        : selSramC ? sramRdata
        : hitRom ? romRdata : periphRdata;
    wire logic doneNow = finish && (anyReq || !idle);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= IMRD_ST_IDLE;
            owner_reg <= 1'b0;
            wait_reg <= `IMRD_WS_RESET;
            lastDma_reg <= 1'b0;
        end else if (clkEn) begin
            state_reg <= state_next;
            owner_reg <= owner_next;
            wait_reg <= startWait ? wsClamp - 2'h1
                : (wait_reg != 2'h0 ? wait_reg - 2'h1 : wait_reg);
            if (doneNow || abortNow) begin
                lastDma_reg <= curDma;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            remap_reg <= 1'b0;
        end else if (clkEn && remapCmd) begin
            remap_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_reg <= '0;
        end else if (clkEn && doneNow && !wSel) begin
            rd_reg <= rdMux;
        end
    end

    // =============================================================
    // abort status: new abort wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            abtV_reg <= 1'b0;
            abtDma_reg <= 1'b0;
            abtT_reg <= 2'h0;
            abtA_reg <= '0;
            abtW_reg <= 1'b0;
            abtS_reg <= 2'h0;
        end else if (clkEn) begin
            if (abortNow) begin
                abtV_reg <= 1'b1;
                abtDma_reg <= curDma;
                abtT_reg <= misC ? `IMRD_ABT_MISALIGN : `IMRD_ABT_UNDEF;
                abtA_reg <= aSel;
                abtW_reg <= wSel;
                abtS_reg <= szSel;
            end else if (abortClear) begin
                abtV_reg <= 1'b0;
            end
        end
    end

    // =============================================================
    // outputs
    assign cpuGnt = active && !curDma;
    assign dmaGnt = active && curDma;
    assign cpuDone = clkEn && doneNow && !curDma;
    assign dmaDone = clkEn && doneNow && curDma;
    assign cpuAbort = clkEn && abortNow && !curDma;
    assign dmaAbort = clkEn && abortNow && curDma;
    assign rdData = rd_reg;
    assign remapped = remap_reg;
    assign flashSel = active && !abortC && selFlashC;
    assign sramSel = active && !abortC && selSramC;
    assign romSel = active && !abortC && hitRom;
    assign periphSel = active && !abortC && selPerC;
    assign memAddr = aSel;
    assign memWrite = active && wSel;
    assign memSize = szSel;
    assign memWdata = curDma ? dmaWdata : cpuWdata;
    assign abortValid = abtV_reg;
    assign abortFromDma = abtDma_reg;
    assign abortType = abtT_reg;
    assign abortAddr = abtA_reg;
    assign abortWrite = abtW_reg;
    assign abortSize = abtS_reg;

endmodule

// [pkg/imrd_defines.svh]
/*
 holds address map constants, field widths and reset values of the remap decoder.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef IMRD_DEFINES_SVH
`define IMRD_DEFINES_SVH

`define IMRD_AREA_LSB 20
`define IMRD_AREA_W 8
`define IMRD_AREA_BOOT 8'h00
`define IMRD_AREA_FLASH 8'h01
`define IMRD_AREA_SRAM 8'h02
`define IMRD_AREA_ROM 8'h03
`define IMRD_INT_MSB 31
`define IMRD_INT_W 4
`define IMRD_INT_REGION 4'h0
`define IMRD_PERIPH_REGION 4'hf
`define IMRD_WS_MAX 2'h3
`define IMRD_WS_RESET 2'h0
`define IMRD_SIZE_BYTE 2'h0
`define IMRD_SIZE_HALF 2'h1
`define IMRD_SIZE_WORD 2'h2
`define IMRD_ABT_MISALIGN 2'h1
`define IMRD_ABT_UNDEF 2'h2

`endif

// [pkg/imrd_pkg.sv]
/*
 holds the types of the remap decoder.
 assumes the defines header sits beside it.
*/
`include "imrd_defines.svh"

package imrd_pkg;
    typedef enum logic [1:0] {
        IMRD_SEL_NONE,
        IMRD_SEL_FLASH,
        IMRD_SEL_SRAM,
        IMRD_SEL_ROM
    } imrd_sel_type;

    typedef enum logic [1:0] {
        IMRD_ST_IDLE,
        IMRD_ST_WAIT,
        IMRD_ST_DONE
    } imrd_state_type;
endpackage
